// ---- pkg/sbcom_defs.svh ----
`ifndef SBCOM_DEFS_SVH
`define SBCOM_DEFS_SVH
// Purpose: Named constants of the operating mode controller.
// Assumes: 200 MHz system clock.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.

// ----------------------------------------
// Timing
// ----------------------------------------
`define SBCOM_CLK_NS 5
`define SBCOM_SHORT_RST_NS 3600000
`define SBCOM_LONG_RST_NS 20000000
`define SBCOM_CNT_W 24

// ----------------------------------------
// Register map
// ----------------------------------------
`define SBCOM_ADDR_W 8
`define SBCOM_CTRL_OFS 8'h00
`define SBCOM_STAT_OFS 8'h04
`define SBCOM_WAKE_OFS 8'h08
`define SBCOM_CTRL_MODE 0
`define SBCOM_CTRL_CANLP 2
`define SBCOM_CTRL_LIN1LP 3
`define SBCOM_CTRL_LIN2LP 4
`define SBCOM_CTRL_WMC 5
`define SBCOM_CTRL_LONGRST 6
`define SBCOM_CTRL_WAKEEN 7
`define SBCOM_STAT_RST 5
`define SBCOM_STAT_LHC 6
`define SBCOM_STAT_WDPIN 7
`define SBCOM_WAKE_LHC 8
`define SBCOM_WAKEEN_RST 5'h1F
`define SBCOM_RESP_OKAY 2'h0
`define SBCOM_RESP_SLVERR 2'h2

// ----------------------------------------
// Mode select codes
// ----------------------------------------
`define SBCOM_MC_STANDBY 2'h0
`define SBCOM_MC_SLEEP 2'h1
`define SBCOM_MC_NORMAL_V2OFF 2'h2
`define SBCOM_MC_NORMAL_V2ON 2'h3
`endif

// ---- pkg/sbcom_pkg.sv ----
// Purpose: Types of the operating mode controller.
// Assumes: Constants come from sbcom_defs.svh.
// Notes: The whole module state is one packed struct.
`include "sbcom_defs.svh"
package sbcom_pkg;
	typedef enum logic [4:0] {
		MODE_OFF = 5'h01,
		MODE_STANDBY = 5'h02,
		MODE_NORMAL = 5'h04,
		MODE_SLEEP = 5'h08,
		MODE_OVERTEMP = 5'h10
	} sbcom_mode_t;

	typedef enum logic [1:0] {
		TRX_OFF = 2'h0,
		TRX_LOWPOWER = 2'h1,
		TRX_ACTIVE = 2'h2
	} sbcom_trx_t;

	typedef enum logic [1:0] {
		WD_OFF = 2'h0,
		WD_TIMEOUT = 2'h1,
		WD_WINDOW = 2'h2
	} sbcom_wdog_t;

	typedef struct packed {
		logic awvalid;
		logic [`SBCOM_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`SBCOM_ADDR_W-1:0] araddr;
		logic rready;
	} sbcom_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sbcom_axi_rsp_t;

	typedef struct packed {
		sbcom_mode_t mode;
		logic [1:0] batSync1;
		logic [1:0] batSync2;
		logic [1:0] tempSync1;
		logic [1:0] tempSync2;
		logic [1:0] modeSel;
		logic canLp;
		logic lin1Lp;
		logic lin2Lp;
		logic watchdog_mode_select;
		logic longRst;
		logic [4:0] wakeEn;
		logic [4:0] wakeFlags;
		logic limp_home_ctrl_bit;
		logic reqPend;
		logic [`SBCOM_CNT_W-1:0] rstCnt;
		logic awHave;
		logic [`SBCOM_ADDR_W-1:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		sbcom_axi_rsp_t rsp;
		logic mainRegEn;
		logic canRegEn;
		sbcom_trx_t canTrx;
		sbcom_trx_t lin1Trx;
		sbcom_trx_t lin2Trx;
		sbcom_wdog_t wdog;
		logic rstOut;
		logic rstOe;
		logic limpOutN;
	} sbcom_state_t;
endpackage

// ---- src/sbcom_mode_ctrl.sv ----
// Purpose: Operating mode controller of a CAN/LIN system basis chip.
// Assumes: Detector and wake inputs are synchronous pulses or levels; one clock.
// Notes: Registers sit on an AXI4-Lite slave; reset line is open drain.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`include "sbcom_defs.svh"

module sbcom_mode_ctrl
	import sbcom_pkg::*;
#(
	parameter int unsigned SHORT_RST_CYC =
		(`SBCOM_SHORT_RST_NS + `SBCOM_CLK_NS - 1) / `SBCOM_CLK_NS,
	parameter int unsigned LONG_RST_CYC =
		(`SBCOM_LONG_RST_NS + `SBCOM_CLK_NS - 1) / `SBCOM_CLK_NS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire sbcom_axi_req_t axiReq,
	output sbcom_axi_rsp_t axiRsp,
	input wire logic batBelowOff,
	input wire logic batAboveOn,
	input wire logic tempAboveAct,
	input wire logic tempBelowRel,
	input wire logic canWake,
	input wire logic lin1Wake,
	input wire logic lin2Wake,
	input wire logic localWakeIn1,
	input wire logic localWakeIn2,
	input wire logic interruptOutN,
	input wire logic watchdogDisablePin,
	input wire logic resetLineNIn,
	output logic resetLineNOut,
	output logic resetLineNOe,
	output logic mainRegulatorEn,
	output logic canRegulatorEn,
	output sbcom_trx_t canTrxState,
	output sbcom_trx_t lin1TrxState,
	output sbcom_trx_t lin2TrxState,
	output sbcom_wdog_t watchdogMode,
	output logic limpOutN,
	output sbcom_mode_t modeOut
);
	localparam int CW = `SBCOM_CNT_W;
	sbcom_state_t s_q;
	sbcom_state_t s_d;
	logic [4:0] wakeEv;
	logic [31:0] ctrlWord;
	logic [31:0] ctrlNew;
	logic [31:0] rdWord;
	logic batOff;
	logic batOn;
	logic tempAct;
	logic tempRel;
	logic extRst;
	logic sleepOk;
	logic [CW-1:0] sysRstLen;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction
	function automatic sbcom_trx_t lowOrOff(input logic lp);
		return lp ? TRX_LOWPOWER : TRX_OFF;
	endfunction
	function automatic sbcom_trx_t lowOrActive(input logic lp);
		return lp ? TRX_LOWPOWER : TRX_ACTIVE;
	endfunction
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		wakeEv = {localWakeIn2, localWakeIn1, lin2Wake, lin1Wake, canWake};
		ctrlWord = '0;
		ctrlWord[`SBCOM_CTRL_MODE +: 2] = s_q.modeSel;
		ctrlWord[`SBCOM_CTRL_CANLP] = s_q.canLp;
		ctrlWord[`SBCOM_CTRL_LIN1LP] = s_q.lin1Lp;
		ctrlWord[`SBCOM_CTRL_LIN2LP] = s_q.lin2Lp;
		ctrlWord[`SBCOM_CTRL_WMC] = s_q.watchdog_mode_select;
		ctrlWord[`SBCOM_CTRL_LONGRST] = s_q.longRst;
		ctrlWord[`SBCOM_CTRL_WAKEEN +: 5] = s_q.wakeEn;
		ctrlNew = mergeBytes(ctrlWord, s_q.wData, s_q.wStrb);
		rdWord = '0;
		// Detectors pass two flops before the mode logic sees them.
		s_d.batSync1 = {batBelowOff, batAboveOn};
		s_d.batSync2 = s_q.batSync1;
		s_d.tempSync1 = {tempAboveAct, tempBelowRel};
		s_d.tempSync2 = s_q.tempSync1;
		batOff = s_q.batSync2[1];
		batOn = s_q.batSync2[0];
		tempAct = s_q.tempSync2[1];
		tempRel = s_q.tempSync2[0];
		extRst = !resetLineNIn && !s_q.rstOe;
		sleepOk = interruptOutN && (s_q.wakeFlags == '0) && (s_q.wakeEn != '0);
		sysRstLen = s_q.longRst ? CW'(LONG_RST_CYC) : CW'(SHORT_RST_CYC);
		s_d.reqPend = 1'b0;
		// ----------------------------------------
		// AXI4-Lite write channel
		// ----------------------------------------
		if (axiReq.awvalid && s_q.rsp.awready) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && s_q.rsp.wready) begin
			s_d.wHave = 1'b1;
			s_d.wData = axiReq.wdata;
			s_d.wStrb = axiReq.wstrb;
		end
		if (s_q.rsp.bvalid && axiReq.bready) begin
			s_d.rsp.bvalid = 1'b0;
		end
		if (s_q.awHave && s_q.wHave && !s_q.rsp.bvalid) begin
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			s_d.rsp.bresp = `SBCOM_RESP_OKAY;
			case (s_q.awAddr)
				`SBCOM_CTRL_OFS: begin
					s_d.modeSel = ctrlNew[`SBCOM_CTRL_MODE +: 2];
					s_d.canLp = ctrlNew[`SBCOM_CTRL_CANLP];
					s_d.lin1Lp = ctrlNew[`SBCOM_CTRL_LIN1LP];
					s_d.lin2Lp = ctrlNew[`SBCOM_CTRL_LIN2LP];
					s_d.watchdog_mode_select = ctrlNew[`SBCOM_CTRL_WMC];
					s_d.longRst = ctrlNew[`SBCOM_CTRL_LONGRST];
					s_d.wakeEn = ctrlNew[`SBCOM_CTRL_WAKEEN +: 5];
					s_d.reqPend = s_q.wStrb[0];
				end
				`SBCOM_STAT_OFS: begin
				end
				`SBCOM_WAKE_OFS: begin
					if (s_q.wStrb[0]) begin
						s_d.wakeFlags = s_q.wakeFlags & ~s_q.wData[4:0];
					end
					if (s_q.wStrb[1] && s_q.wData[`SBCOM_WAKE_LHC]) begin
						s_d.limp_home_ctrl_bit = 1'b0;
					end
				end
				default: begin
					s_d.rsp.bresp = `SBCOM_RESP_SLVERR;
				end
			endcase
		end
		s_d.rsp.awready = !s_d.awHave;
		s_d.rsp.wready = !s_d.wHave;
		// ----------------------------------------
		// AXI4-Lite read channel
		// ----------------------------------------
		if (s_q.rsp.rvalid && axiReq.rready) begin
			s_d.rsp.rvalid = 1'b0;
		end
		if (axiReq.arvalid && s_q.rsp.arready) begin
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rresp = `SBCOM_RESP_OKAY;
			case (axiReq.araddr)
				`SBCOM_CTRL_OFS: begin
					rdWord = ctrlWord;
				end
				`SBCOM_STAT_OFS: begin
					rdWord[4:0] = s_q.mode;
					rdWord[`SBCOM_STAT_RST] = s_q.rstOe;
					rdWord[`SBCOM_STAT_LHC] = s_q.limp_home_ctrl_bit;
					rdWord[`SBCOM_STAT_WDPIN] = watchdogDisablePin;
				end
				`SBCOM_WAKE_OFS: begin
					rdWord[4:0] = s_q.wakeFlags;
					rdWord[`SBCOM_WAKE_LHC] = s_q.limp_home_ctrl_bit;
				end
				default: begin
					s_d.rsp.rresp = `SBCOM_RESP_SLVERR;
				end
			endcase
			s_d.rsp.rdata = rdWord;
		end
		s_d.rsp.arready = !s_d.rsp.rvalid;
		// A wake arriving while software clears its flag is kept.
		s_d.wakeFlags = s_d.wakeFlags | wakeEv;
		// ----------------------------------------
		// Mode state machine
		// ----------------------------------------
		if (s_q.rstCnt != '0) begin
			s_d.rstCnt = s_q.rstCnt - CW'(1);
		end
		if (batOff) begin
			s_d.mode = MODE_OFF;
			s_d.rstCnt = '0;
		end else begin
			case (s_q.mode)
				MODE_OFF: begin
					if (batOn) begin
						s_d.mode = MODE_STANDBY;
						s_d.modeSel = `SBCOM_MC_STANDBY;
						s_d.rstCnt = sysRstLen;
					end
				end
				MODE_STANDBY: begin
					if (tempAct) begin
						s_d.mode = MODE_OVERTEMP;
						s_d.limp_home_ctrl_bit = 1'b1;
					end else if (s_q.reqPend) begin
						case (s_q.modeSel)
							`SBCOM_MC_NORMAL_V2OFF, `SBCOM_MC_NORMAL_V2ON: begin
								s_d.mode = MODE_NORMAL;
							end
							`SBCOM_MC_SLEEP: begin
								if (sleepOk) begin
									s_d.mode = MODE_SLEEP;
								end else begin
									s_d.modeSel = `SBCOM_MC_STANDBY;
									s_d.rstCnt = CW'(SHORT_RST_CYC);
								end
							end
							default: begin
							end
						endcase
					end
				end
				MODE_NORMAL: begin
					if (tempAct) begin
						s_d.mode = MODE_OVERTEMP;
						s_d.limp_home_ctrl_bit = 1'b1;
					end else if (extRst) begin
						s_d.mode = MODE_STANDBY;
						s_d.modeSel = `SBCOM_MC_STANDBY;
					end else if (s_q.reqPend) begin
						case (s_q.modeSel)
							`SBCOM_MC_STANDBY: begin
								s_d.mode = MODE_STANDBY;
							end
							`SBCOM_MC_SLEEP: begin
								if (sleepOk) begin
									s_d.mode = MODE_SLEEP;
								end else begin
									s_d.mode = MODE_STANDBY;
									s_d.modeSel = `SBCOM_MC_STANDBY;
									s_d.rstCnt = CW'(SHORT_RST_CYC);
								end
							end
							default: begin
							end
						endcase
					end
				end
				MODE_SLEEP: begin
					if ((wakeEv & s_q.wakeEn) != '0) begin
						s_d.mode = MODE_STANDBY;
						s_d.modeSel = `SBCOM_MC_STANDBY;
						s_d.rstCnt = sysRstLen;
					end else if (s_q.reqPend) begin
						s_d.modeSel = `SBCOM_MC_SLEEP;
					end
				end
				MODE_OVERTEMP: begin
					if (tempRel && !tempAct) begin
						s_d.mode = MODE_STANDBY;
						s_d.modeSel = `SBCOM_MC_STANDBY;
						s_d.rstCnt = sysRstLen;
					end
				end
				default: begin
					s_d.mode = MODE_OFF;
				end
			endcase
		end

		// ----------------------------------------
		// Outputs follow the next mode
		// ----------------------------------------
		s_d.mainRegEn = 1'b0;
		s_d.canRegEn = 1'b0;
		s_d.canTrx = TRX_OFF;
		s_d.lin1Trx = TRX_OFF;
		s_d.lin2Trx = TRX_OFF;
		s_d.wdog = WD_OFF;
		case (s_d.mode)
			MODE_STANDBY: begin
				s_d.mainRegEn = 1'b1;
				s_d.canTrx = lowOrOff(s_d.canLp);
				s_d.lin1Trx = lowOrOff(s_d.lin1Lp);
				s_d.lin2Trx = lowOrOff(s_d.lin2Lp);
				s_d.wdog = (watchdogDisablePin || s_d.watchdog_mode_select) ? WD_OFF : WD_TIMEOUT;
			end
			MODE_NORMAL: begin
				s_d.mainRegEn = 1'b1;
				s_d.canRegEn = (s_d.modeSel == `SBCOM_MC_NORMAL_V2ON);
				s_d.canTrx = lowOrActive(s_d.canLp);
				s_d.lin1Trx = lowOrActive(s_d.lin1Lp);
				s_d.lin2Trx = lowOrActive(s_d.lin2Lp);
				if (!watchdogDisablePin) begin
					s_d.wdog = s_d.watchdog_mode_select ? WD_TIMEOUT : WD_WINDOW;
				end
			end
			MODE_SLEEP: begin
				s_d.canTrx = lowOrOff(s_d.canLp);
				s_d.lin1Trx = lowOrOff(s_d.lin1Lp);
				s_d.lin2Trx = lowOrOff(s_d.lin2Lp);
			end
			default: begin
			end
		endcase
		s_d.rstOut = 1'b0;
		s_d.rstOe = (s_d.rstCnt != '0) || (s_d.mode == MODE_SLEEP)
			|| (s_d.mode == MODE_OVERTEMP);
		s_d.limpOutN = !s_d.limp_home_ctrl_bit;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.mode <= MODE_OFF;
			s_q.wakeEn <= `SBCOM_WAKEEN_RST;
			s_q.rsp.awready <= 1'b1;
			s_q.rsp.wready <= 1'b1;
			s_q.rsp.arready <= 1'b1;
			s_q.limpOutN <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign axiRsp = s_q.rsp;
	assign resetLineNOut = s_q.rstOut;
	assign resetLineNOe = s_q.rstOe;
	assign mainRegulatorEn = s_q.mainRegEn;
	assign canRegulatorEn = s_q.canRegEn;
	assign canTrxState = s_q.canTrx;
	assign lin1TrxState = s_q.lin1Trx;
	assign lin2TrxState = s_q.lin2Trx;
	assign watchdogMode = s_q.wdog;
	assign limpOutN = s_q.limpOutN;
	assign modeOut = s_q.mode;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_off_on_battery: assert property (s_q.batSync2[1] |=> s_q.mode == MODE_OFF &&
		!mainRegulatorEn && !canRegulatorEn && canTrxState == TRX_OFF)
		else $error("battery loss did not force off");
	a_power_up_reset: assert property (s_q.mode == MODE_OFF && !s_q.batSync2[1]
		&& s_q.batSync2[0] |=> s_q.mode == MODE_STANDBY && resetLineNOe [*8])
		else $error("power up reset missing");
	a_sleep_wake: assert property (s_q.mode == MODE_SLEEP && !s_q.batSync2[1]
		&& (wakeEv & s_q.wakeEn) != '0 |=> s_q.mode == MODE_STANDBY
		&& s_q.modeSel == `SBCOM_MC_STANDBY && mainRegulatorEn && resetLineNOe)
		else $error("wake from sleep wrong");
	a_normal_leave: assert property (s_q.mode == MODE_NORMAL && !s_q.batSync2[1]
		&& !s_q.tempSync2[1] && s_q.reqPend && s_q.modeSel == `SBCOM_MC_STANDBY
		|=> s_q.mode == MODE_STANDBY)
		else $error("normal did not return to standby");
	a_standby_wdog: assert property (s_q.mode == MODE_STANDBY |-> mainRegulatorEn
		&& watchdogMode == (($past(watchdogDisablePin) || s_q.watchdog_mode_select) ? WD_OFF : WD_TIMEOUT))
		else $error("standby watchdog mode wrong");
	a_normal_entry: assert property (s_q.mode == MODE_STANDBY && !s_q.batSync2[1]
		&& !s_q.tempSync2[1] && s_q.reqPend && s_q.modeSel[1] |=> s_q.mode == MODE_NORMAL
		&& canRegulatorEn == $past(s_q.modeSel[0]))
		else $error("normal entry wrong");
	a_sleep_refuse: assert property (s_q.mode == MODE_NORMAL && !s_q.batSync2[1]
		&& !s_q.tempSync2[1] && s_q.reqPend && s_q.modeSel == `SBCOM_MC_SLEEP
		&& !interruptOutN |=> s_q.mode == MODE_STANDBY && s_q.rstCnt == CW'(SHORT_RST_CYC))
		else $error("refused sleep without short reset");
	a_sleep_outputs: assert property (s_q.mode == MODE_SLEEP |-> !mainRegulatorEn
		&& !canRegulatorEn && watchdogMode == WD_OFF && resetLineNOe)
		else $error("sleep outputs wrong");
	a_overtemp_entry: assert property (s_q.tempSync2[1] && !s_q.batSync2[1]
		&& (s_q.mode == MODE_NORMAL || s_q.mode == MODE_STANDBY)
		|=> s_q.mode == MODE_OVERTEMP && !limpOutN && resetLineNOe && !mainRegulatorEn)
		else $error("overtemp entry wrong");
	a_normal_trx: assert property (s_q.mode == MODE_NORMAL |-> canTrxState
		== (s_q.canLp ? TRX_LOWPOWER : TRX_ACTIVE))
		else $error("normal can transceiver wrong");
endmodule

// ---- tb/sbcom_mcu_model.sv ----
// Purpose: Microcontroller side of the reset wire and interrupt pin.
// Assumes: The reset wire has a pull-up; both parties only pull it low.
// Notes: The bench steers this model through its two request inputs.
module sbcom_mcu_model (
	input wire logic devOe,
	input wire logic devOut,
	input wire logic mcuPullLow,
	input wire logic intPending,
	output logic resetWireN,
	output logic interruptOutN
);
	timeunit 1ns;
	timeprecision 1ps;

	// The wire is low while either side pulls it and high otherwise.
	assign resetWireN = !((devOe && !devOut) || mcuPullLow);
	assign interruptOutN = !intPending;
endmodule

// ---- tb/sbc_operating_mode_controller_test.sv ----
// Purpose: Self-checking bench of the operating mode controller.
// Assumes: Short and long reset widths shortened to 8 and 16 cycles.
// Notes: Expected outputs come from a mode model kept in integers.
module sbc_operating_mode_controller_test;
	import sbcom_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	localparam int SHORT = 8;
	localparam int LONG = 16;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	sbcom_axi_req_t axiReq = '0;
	sbcom_axi_rsp_t axiRsp;
	logic batBelowOff = 1'b0;
	logic batAboveOn = 1'b0;
	logic tempAboveAct = 1'b0;
	logic tempBelowRel = 1'b1;
	logic [4:0] wk = 5'h00;
	logic wdPin = 1'b0;
	logic mcuPull = 1'b0;
	logic intPend = 1'b0;
	logic interruptOutN, resetWireN, resetLineNOut, resetLineNOe;
	logic mainRegulatorEn, canRegulatorEn, limpOutN;
	sbcom_trx_t canTrxState, lin1TrxState, lin2TrxState;
	sbcom_wdog_t watchdogMode;
	sbcom_mode_t modeOut;
	int nMismatch = 0;
	int checkCount = 0;
	int seed = 46576;
	int code, clp, l1p, l2p, watchdog_mode_select, lrst, wen, pin;
	logic [31:0] d;
	logic [1:0] r;

	always #2.5 clk_sys = ~clk_sys;

	sbcom_mode_ctrl #(.SHORT_RST_CYC(SHORT), .LONG_RST_CYC(LONG)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
		.batBelowOff(batBelowOff), .batAboveOn(batAboveOn),
		.tempAboveAct(tempAboveAct), .tempBelowRel(tempBelowRel),
		.canWake(wk[0]), .lin1Wake(wk[1]), .lin2Wake(wk[2]),
		.localWakeIn1(wk[3]), .localWakeIn2(wk[4]),
		.interruptOutN(interruptOutN), .watchdogDisablePin(wdPin),
		.resetLineNIn(resetWireN), .resetLineNOut(resetLineNOut),
		.resetLineNOe(resetLineNOe), .mainRegulatorEn(mainRegulatorEn),
		.canRegulatorEn(canRegulatorEn), .canTrxState(canTrxState),
		.lin1TrxState(lin1TrxState), .lin2TrxState(lin2TrxState),
		.watchdogMode(watchdogMode), .limpOutN(limpOutN), .modeOut(modeOut)
	);

	sbcom_mcu_model u_mcu (
		.devOe(resetLineNOe), .devOut(resetLineNOut), .mcuPullLow(mcuPull),
		.intPending(intPend), .resetWireN(resetWireN), .interruptOutN(interruptOutN)
	);

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic endSim();
		$display("checks %0d mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checkCount++;
		if (s !== e) begin
			nMismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk_sys);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= v;
		axiReq.wstrb <= 4'hF;
		axiReq.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
		end while (!axiRsp.bvalid && n < 200);
		rs = axiRsp.bresp;
		axiReq.bready <= 1'b0;
		if (n >= 200) nMismatch++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk_sys);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
		end while (!axiRsp.rvalid && n < 200);
		v = axiRsp.rdata;
		rs = axiRsp.rresp;
		axiReq.rready <= 1'b0;
		if (n >= 200) nMismatch++;
	endtask

	function automatic logic [31:0] ctrlw();
		return {20'h0, wen[4:0], lrst[0], watchdog_mode_select[0], l2p[0], l1p[0], clp[0], code[1:0]};
	endfunction

	// Writes the model's control word; the request acts within a few edges.
	task automatic setc();
		wr(`SBCOM_CTRL_OFS, ctrlw(), r);
		chk(r, `SBCOM_RESP_OKAY);
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic rstw(input int n);
		int c, t;
		c = 0;
		t = 0;
		while (!resetLineNOe && t < 200) begin
			@(posedge clk_sys);
			t++;
		end
		while (resetLineNOe && c < 1000) begin
			@(posedge clk_sys);
			c++;
		end
		chk(c, n);
	endtask

	task automatic waitlow();
		int t;
		t = 0;
		while (resetLineNOe && t < LONG + 40) begin
			@(posedge clk_sys);
			t++;
		end
		chk(resetLineNOe, 1'b0);
	endtask

	// Mode model: supplies, transceivers and watchdog for mode m.
	task automatic chk_mode(input int m);
		int t0, t1, t2, wd;
		t0 = (m == 1 || m == 16) ? 0 : clp ? 1 : (m == 4) ? 2 : 0;
		t1 = (m == 1 || m == 16) ? 0 : l1p ? 1 : (m == 4) ? 2 : 0;
		t2 = (m == 1 || m == 16) ? 0 : l2p ? 1 : (m == 4) ? 2 : 0;
		wd = pin ? 0 : (m == 4) ? (watchdog_mode_select ? 1 : 2) : (m == 2) ? (watchdog_mode_select ? 0 : 1) : 0;
		chk({modeOut, mainRegulatorEn, canRegulatorEn, canTrxState,
			lin1TrxState, lin2TrxState, watchdogMode},
			{m[4:0], (m == 2 || m == 4), (m == 4 && code == 3), t0[1:0], t1[1:0],
			t2[1:0], wd[1:0]});
	endtask

	initial begin
		#200000;
		nMismatch++;
		endSim();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		code = 0; clp = 0; l1p = 0; l2p = 0; watchdog_mode_select = 0; lrst = 0; wen = 31; pin = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk_mode(1);
		rd(`SBCOM_CTRL_OFS, d, r);
		chk(d, 32'h0000_0F80);
		batAboveOn <= 1'b1;
		rstw(SHORT);
		chk_mode(2);
		for (int i = 0; i < 6; i++) begin
			clp = $random(seed) & 1;
			l1p = $random(seed) & 1;
			l2p = $random(seed) & 1;
			watchdog_mode_select = $random(seed) & 1;
			pin = (i == 5);
			wdPin <= pin[0];
			code = 0;
			setc();
			chk_mode(2);
			code = 2 + (i & 1);
			setc();
			chk_mode(4);
			code = 0;
			setc();
			chk_mode(2);
		end
		pin = 0;
		wdPin <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			code = (k == 1) ? 0 : 2;
			wen = (k == 2) ? 0 : 31;
			setc();
			if (k == 0) intPend <= 1'b1;
			if (k == 1) wk <= 5'h02;
			@(posedge clk_sys);
			wk <= 5'h00;
			code = 1;
			wr(`SBCOM_CTRL_OFS, ctrlw(), r);
			rstw(SHORT);
			chk_mode(2);
			intPend <= 1'b0;
			wen = 31;
			wr(`SBCOM_WAKE_OFS, 32'h0000_001F, r);
		end
		lrst = 1;
		for (int s = 0; s < 5; s++) begin
			code = (s & 1) ? 2 : 0;
			setc();
			code = 1;
			setc();
			chk_mode(8);
			chk({resetLineNOe, resetLineNOut}, 2'b10);
			code = 2;
			setc();
			chk_mode(8);
			wk <= 5'h01 << s;
			@(posedge clk_sys);
			wk <= 5'h00;
			repeat (4) @(posedge clk_sys);
			code = 0;
			chk_mode(2);
			waitlow();
			rd(`SBCOM_CTRL_OFS, d, r);
			chk(d[1:0], 2'h0);
			wr(`SBCOM_WAKE_OFS, 32'h0000_001F, r);
		end
		code = 3;
		setc();
		chk_mode(4);
		mcuPull <= 1'b1;
		repeat (2) @(posedge clk_sys);
		mcuPull <= 1'b0;
		repeat (4) @(posedge clk_sys);
		waitlow();
		chk_mode(2);
		code = 2;
		setc();
		tempBelowRel <= 1'b0;
		tempAboveAct <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk_mode(16);
		chk({resetLineNOe, limpOutN}, 2'b10);
		tempAboveAct <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk_mode(16);
		tempBelowRel <= 1'b1;
		repeat (5) @(posedge clk_sys);
		waitlow();
		chk_mode(2);
		rd(`SBCOM_WAKE_OFS, d, r);
		chk(d[8], 1'b1);
		wr(`SBCOM_WAKE_OFS, 32'h0000_0100, r);
		repeat (3) @(posedge clk_sys);
		chk(limpOutN, 1'b1);
		rd(8'h0C, d, r);
		chk(r, `SBCOM_RESP_SLVERR);
		chk(d, 32'h0000_0000);
		wr(`SBCOM_STAT_OFS, 32'hFFFF_FFFF, r);
		chk(r, `SBCOM_RESP_OKAY);
		rd(`SBCOM_STAT_OFS, d, r);
		chk(d[7:0], 8'h02);
		rd(`SBCOM_CTRL_OFS, d, r);
		chk(d[11:2], ctrlw() >> 2);
		batBelowOff <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk_mode(1);
		endSim();
	end
endmodule
